// ---- pkg/param_codec_defines.svh ----
// Constants of the parameter channel codec: field positions, codes, offsets.
// Assumes inclusion by bare name from the package; the design file uses the macros without including it.
`ifndef PARAM_CODEC_DEFINES_SVH
`define PARAM_CODEC_DEFINES_SVH

// ****************************************************************
// Channel word fields
// ****************************************************************
`define RID_HI 15
`define RID_LO 12
`define RSV_BIT 11
`define PNUM_HI 10
`define PNUM_LO 0
`define PAGE_HI 15
`define PAGE_LO 8
`define SUB_HI 7
`define SUB_LO 0
`define BYTE_HI 7
`define CONN_OBJ_HI 15
`define CONN_OBJ_LO 10
`define CONN_IDX_HI 9
`define CONN_IDX_LO 0
`define COMM_READY 8'h0f

// ****************************************************************
// Request and response identifiers
// ****************************************************************
`define RQ_NONE 4'h0
`define RQ_RD 4'h1
`define RQ_WR_W 4'h2
`define RQ_WR_D 4'h3
`define RQ_DESC 4'h4
`define RQ_RD_F 4'h6
`define RQ_WR_FW 4'h7
`define RQ_WR_FD 4'h8
`define RQ_CNT 4'h9
`define RS_NONE 4'h0
`define RS_W 4'h1
`define RS_D 4'h2
`define RS_DESC 4'h3
`define RS_FW 4'h4
`define RS_FD 4'h5
`define RS_CNT 4'h6
`define RS_ERR 4'h7

// ****************************************************************
// Error codes
// ****************************************************************
`define E_NO_PARAM 8'h00
`define E_FIXED 8'h01
`define E_LIMIT 8'h02
`define E_SUBIDX 8'h03
`define E_NO_ARRAY 8'h04
`define E_DTYPE 8'h05
`define E_RESET_ONLY 8'h06
`define E_DESC_FIXED 8'h07
`define E_NO_MASTER 8'h0b
`define E_KEYWORD 8'h0c
`define E_OP_STATE 8'h11
`define E_BAD_VALUE 8'h14
`define E_INACTIVE 8'h65
`define E_NARROW 8'h66
`define E_ILLEGAL 8'h68
`define E_NO_TASK 8'h6a
`define E_RUNNING 8'h6b
`define E_COMMISSION 8'h86
`define E_KNOWHOW 8'h87
`define E_BELOW 8'hc8
`define E_ABOVE 8'hc9
`define E_NO_KEY 8'hcc

// ****************************************************************
// Page index codes and range offsets
// ****************************************************************
`define PG_0 8'h00
`define PG_2K 8'h80
`define PG_6K 8'h90
`define PG_8K 8'h20
`define PG_10K 8'ha0
`define PG_20K 8'h50
`define PG_30K 8'hf0
`define PG_60K 8'h74
`define OFS_0 16'h0000
`define OFS_2K 16'h07d0
`define OFS_6K 16'h1770
`define OFS_8K 16'h1f40
`define OFS_10K 16'h2710
`define OFS_20K 16'h4e20
`define OFS_30K 16'h7530
`define OFS_60K 16'hea60

// ****************************************************************
// Register port map and control fields
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_COMM 4'h4
`define REG_STAT 4'h8
`define REG_ECNT 4'hc
`define CTL_LEN_HI 1
`define CTL_LEN_LO 0
`define CTL_MASTER 2
`define CTL_RUN 3
`define CTL_LOCK 4
`define CTL_KEY 5
`define CTL_RESET 6'h04
`endif

// ---- pkg/param_codec_pkg.sv ----
// Types of the parameter channel codec.
// Assumes the defines header sits on the include path.
`include "param_codec_defines.svh"
package param_codec_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_LOOK = 2'b01, ST_COMMIT = 2'b11, ST_ANSWER = 2'b10
  } state_t;
  typedef enum logic [1:0] {
    LEN_NONE = 2'h0, LEN_THREE = 2'h1, LEN_FOUR = 2'h2, LEN_VAR = 2'h3
  } chan_len_t;
  typedef enum logic [1:0] {
    OP_READ = 2'h0, OP_WRITE = 2'h1, OP_DESC = 2'h2, OP_COUNT = 2'h3
  } acc_op_t;
  typedef enum logic [3:0] {
    C_NONE, C_FIXED, C_LIMIT, C_DTYPE, C_DESC_FIXED, C_KEYWORD, C_OP_STATE,
    C_BAD_VALUE, C_INACTIVE, C_ILLEGAL, C_BELOW, C_ABOVE
  } cause_t;
  typedef struct packed {
    state_t st;
    chan_len_t len;
    logic master, run, lock, key;
    logic [7:0] comm;
    logic [15:0] q0, q1, num;
    logic [31:0] qv, val;
    acc_op_t op;
    logic acc_valid, acc_commit;
    logic dw, byt, err;
    logic [7:0] errc;
    logic [15:0] w0, w1, w2, w3;
    logic [2:0] rlen;
    logic rsp_valid;
    logic [31:0] rdata;
    logic [7:0] last_code;
    logic [3:0] last_rid;
    logic [15:0] err_cnt;
  } state_s_t;
endpackage

// ---- hdl/param_channel_request_codec.sv ----
// Parameter channel codec: decodes requests, queries the parameter store,
// encodes positive or negative responses. Assumes framing and checksum are
// handled outside and that the store answers each query with ack_valid.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module param_channel_request_codec (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Request words from the telegram
  input wire logic req_valid,
  input wire logic [15:0] req_w0,
  input wire logic [15:0] req_w1,
  input wire logic [15:0] req_w2,
  input wire logic [15:0] req_w3,
  // Response words to the telegram
  output logic rsp_valid,
  output logic [15:0] rsp_w0,
  output logic [15:0] rsp_w1,
  output logic [15:0] rsp_w2,
  output logic [15:0] rsp_w3,
  output logic [2:0] rsp_len,
  // Query to the parameter store
  output logic acc_valid,
  output logic acc_commit,
  output param_codec_pkg::acc_op_t acc_op,
  output logic [15:0] acc_num,
  output logic [7:0] acc_elem,
  output logic acc_dword,
  output logic [31:0] acc_value,
  output logic [5:0] acc_conn_obj,
  output logic [9:0] acc_conn_idx,
  // Answer from the parameter store
  input wire logic ack_valid,
  input wire logic ack_exists,
  input wire logic ack_indexed,
  input wire logic [7:0] ack_elems,
  input wire logic ack_reset_only,
  input wire logic ack_needs_stop,
  input wire logic ack_commission,
  input wire logic ack_dword,
  input wire logic ack_byte,
  input wire logic ack_conn,
  input wire param_codec_pkg::cause_t ack_cause,
  input wire logic [31:0] ack_value
);
  import param_codec_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Page index to range offset, top bit flags a known code
  function automatic logic [16:0] page_ofs(input logic [7:0] pg);
    case (pg)
      `PG_0: page_ofs = {1'b1, `OFS_0};
      `PG_2K: page_ofs = {1'b1, `OFS_2K};
      `PG_6K: page_ofs = {1'b1, `OFS_6K};
      `PG_8K: page_ofs = {1'b1, `OFS_8K};
      `PG_10K: page_ofs = {1'b1, `OFS_10K};
      `PG_20K: page_ofs = {1'b1, `OFS_20K};
      `PG_30K: page_ofs = {1'b1, `OFS_30K};
      `PG_60K: page_ofs = {1'b1, `OFS_60K};
      default: page_ofs = {1'b0, `OFS_0};
    endcase
  endfunction

  // Store fault cause to error code
  function automatic logic [7:0] cause_code(input cause_t c);
    case (c)
      C_FIXED: cause_code = `E_FIXED;
      C_LIMIT: cause_code = `E_LIMIT;
      C_DTYPE: cause_code = `E_DTYPE;
      C_DESC_FIXED: cause_code = `E_DESC_FIXED;
      C_KEYWORD: cause_code = `E_KEYWORD;
      C_OP_STATE: cause_code = `E_OP_STATE;
      C_BAD_VALUE: cause_code = `E_BAD_VALUE;
      C_ILLEGAL: cause_code = `E_ILLEGAL;
      C_INACTIVE: cause_code = `E_INACTIVE;
      C_BELOW: cause_code = `E_BELOW;
      C_ABOVE: cause_code = `E_ABOVE;
      default: cause_code = `E_ILLEGAL;
    endcase
  endfunction

  // Positive response identifier for a request identifier
  function automatic logic [3:0] pos_rid(input logic [3:0] rq,
                                         input logic dw);
    case (rq)
      `RQ_RD: pos_rid = dw ? `RS_D : `RS_W;
      `RQ_RD_F: pos_rid = dw ? `RS_FD : `RS_FW;
      `RQ_WR_W: pos_rid = `RS_W;
      `RQ_WR_D: pos_rid = `RS_D;
      `RQ_WR_FW: pos_rid = `RS_FW;
      `RQ_WR_FD: pos_rid = `RS_FD;
      `RQ_DESC: pos_rid = `RS_DESC;
      `RQ_CNT: pos_rid = `RS_CNT;
      default: pos_rid = `RS_NONE;
    endcase
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  state_s_t s_reg, s_next;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [3:0] rq;
    logic [16:0] po;
    logic wr, sup, wdw;
    logic [2:0] hi;
    rq = req_w0[`RID_HI:`RID_LO];
    po = page_ofs(req_w1[`PAGE_HI:`PAGE_LO]);
    wr = 1'b0;
    sup = 1'b1;
    wdw = 1'b0;
    hi = (s_reg.len == LEN_FOUR) ? 3'h3 : 3'h2;
    s_next = s_reg;
    s_next.acc_valid = 1'b0;
    s_next.acc_commit = 1'b0;
    s_next.rsp_valid = 1'b0;
    s_next.rdata = 32'h0;

    // Register writes steer the channel checks
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          s_next.len = chan_len_t'(reg_wdata[`CTL_LEN_HI:`CTL_LEN_LO]);
          s_next.master = reg_wdata[`CTL_MASTER];
          s_next.run = reg_wdata[`CTL_RUN];
          s_next.lock = reg_wdata[`CTL_LOCK];
          s_next.key = reg_wdata[`CTL_KEY];
        end
        `REG_COMM: s_next.comm = reg_wdata[7:0];
        default: ;
      endcase
    end

    // Register reads, data in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: s_next.rdata = {26'h0, s_reg.key, s_reg.lock,
                                   s_reg.run, s_reg.master, s_reg.len};
        `REG_COMM: s_next.rdata = {24'h0, s_reg.comm};
        `REG_STAT: s_next.rdata = {19'h0, (s_reg.st != ST_IDLE),
                                   s_reg.last_rid, s_reg.last_code};
        `REG_ECNT: s_next.rdata = {16'h0, s_reg.err_cnt};
        default: s_next.rdata = 32'h0;
      endcase
    end

    case (s_reg.st)
      // Take a request, decode it and run the channel-wide checks
      ST_IDLE: begin
        if (req_valid && s_reg.len != LEN_NONE) begin
          s_next.q0 = req_w0;
          s_next.q1 = req_w1;
          s_next.qv = {req_w2, req_w3};
          s_next.num = 16'(req_w0[`PNUM_HI:`PNUM_LO]) +
                       po[15:0];
          s_next.err = 1'b0;
          s_next.dw = 1'b0;
          s_next.byt = 1'b0;
          s_next.val = 32'h0;
          case (rq)
            `RQ_RD, `RQ_RD_F: s_next.op = OP_READ;
            `RQ_WR_W, `RQ_WR_FW: begin
              s_next.op = OP_WRITE;
              wr = 1'b1;
            end
            `RQ_WR_D, `RQ_WR_FD: begin
              s_next.op = OP_WRITE;
              wr = 1'b1;
              wdw = 1'b1;
            end
            `RQ_DESC: s_next.op = OP_DESC;
            `RQ_CNT: s_next.op = OP_COUNT;
            `RQ_NONE: s_next.op = OP_READ;
            default: sup = 1'b0;
          endcase
          s_next.dw = wdw;
          s_next.st = ST_ANSWER;
          if (!sup) begin
            s_next.err = 1'b1;
            s_next.errc = `E_NO_TASK;
          end else if (rq == `RQ_NONE) begin
            s_next.st = ST_ANSWER;
          end else if (!po[16]) begin
            s_next.err = 1'b1;
            s_next.errc = `E_NO_PARAM;
          end else if (s_reg.lock) begin
            s_next.err = 1'b1;
            s_next.errc = `E_KNOWHOW;
          end else if (wr && !s_reg.master) begin
            s_next.err = 1'b1;
            s_next.errc = `E_NO_MASTER;
          end else if (wr && !s_reg.key) begin
            s_next.err = 1'b1;
            s_next.errc = `E_NO_KEY;
          end else if (wdw && s_reg.len == LEN_THREE) begin
            s_next.err = 1'b1;
            s_next.errc = `E_NARROW;
          end else begin
            s_next.acc_valid = 1'b1;
            s_next.st = ST_LOOK;
          end
        end
      end

      // Check the store's descriptor of the addressed parameter
      ST_LOOK: begin
        if (ack_valid) begin
          s_next.st = ST_ANSWER;
          s_next.err = 1'b1;
          if (!ack_exists) begin
            s_next.errc = `E_NO_PARAM;
          end else if (!ack_indexed && s_reg.q1[`SUB_HI:`SUB_LO] != 8'h0)
          begin
            s_next.errc = `E_NO_ARRAY;
          end else if (ack_indexed &&
                       s_reg.q1[`SUB_HI:`SUB_LO] >= ack_elems) begin
            s_next.errc = `E_SUBIDX;
          end else if (s_reg.op == OP_WRITE) begin
            if (ack_dword != s_reg.dw) begin
              s_next.errc = `E_DTYPE;
            end else if (ack_reset_only && s_reg.qv != 32'h0) begin
              s_next.errc = `E_RESET_ONLY;
            end else if (ack_needs_stop && s_reg.run) begin
              s_next.errc = `E_RUNNING;
            end else if (ack_commission && s_reg.comm != `COMM_READY)
            begin
              s_next.errc = `E_COMMISSION;
            end else begin
              s_next.err = 1'b0;
              s_next.acc_commit = 1'b1;
              s_next.st = ST_COMMIT;
            end
          end else if (ack_cause != C_NONE) begin
            s_next.errc = cause_code(ack_cause);
          end else if ((ack_dword || ack_conn) &&
                       s_reg.len == LEN_THREE) begin
            s_next.errc = `E_NARROW;
          end else begin
            s_next.err = 1'b0;
            s_next.dw = ack_dword | ack_conn;
            s_next.byt = ack_byte;
            s_next.val = (s_reg.op == OP_COUNT) ?
                         {24'h0, ack_elems} : ack_value;
          end
        end
      end

      // Wait for the store to accept or refuse the new value
      ST_COMMIT: begin
        if (ack_valid) begin
          s_next.st = ST_ANSWER;
          s_next.val = s_reg.qv;
          if (ack_cause != C_NONE) begin
            s_next.err = 1'b1;
            s_next.errc = cause_code(ack_cause);
          end
        end
      end

      // Build the response words and publish them for one cycle
      ST_ANSWER: begin
        s_next.st = ST_IDLE;
        s_next.rsp_valid = 1'b1;
        s_next.w1 = s_reg.q1;
        s_next.w2 = 16'h0;
        s_next.w3 = 16'h0;
        if (s_reg.err) begin
          s_next.w0 = {`RS_ERR, 1'b0,
                       s_reg.q0[`PNUM_HI:`PNUM_LO]};
          if (hi == 3'h3) begin
            s_next.w3 = {8'h0, s_reg.errc};
          end else begin
            s_next.w2 = {8'h0, s_reg.errc};
          end
          s_next.rlen = (s_reg.len == LEN_FOUR) ? 3'h4 : 3'h3;
          s_next.last_code = s_reg.errc;
          s_next.last_rid = `RS_ERR;
          s_next.err_cnt = s_reg.err_cnt + 16'h1;
        end else begin
          s_next.w0 = {pos_rid(s_reg.q0[`RID_HI:`RID_LO], s_reg.dw), 1'b0,
                       s_reg.q0[`PNUM_HI:`PNUM_LO]};
          s_next.last_rid = s_next.w0[`RID_HI:`RID_LO];
          if (s_reg.q0[`RID_HI:`RID_LO] == `RQ_NONE) begin
            s_next.w1 = 16'h0;
            s_next.rlen = (s_reg.len == LEN_VAR) ? 3'h2 :
                          (s_reg.len == LEN_FOUR) ? 3'h4 : 3'h3;
          end else if (s_reg.dw) begin
            s_next.w2 = s_reg.val[31:16];
            s_next.w3 = s_reg.val[15:0];
            s_next.rlen = 3'h4;
          end else if (s_reg.len == LEN_FOUR) begin
            s_next.w3 = s_reg.byt ? {8'h0, s_reg.val[`BYTE_HI:0]} :
                        s_reg.val[15:0];
            s_next.rlen = 3'h4;
          end else begin
            s_next.w2 = s_reg.byt ? {8'h0, s_reg.val[`BYTE_HI:0]} :
                        s_reg.val[15:0];
            s_next.rlen = 3'h3;
          end
        end
      end

      default: s_next.st = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.len <= LEN_FOUR;
      {s_reg.key, s_reg.lock, s_reg.run, s_reg.master} <=
        4'(`CTL_RESET >> `CTL_MASTER);
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Register port and response words
  assign reg_rdata = s_reg.rdata;
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_w0 = s_reg.w0;
  assign rsp_w1 = s_reg.w1;
  assign rsp_w2 = s_reg.w2;
  assign rsp_w3 = s_reg.w3;
  assign rsp_len = s_reg.rlen;

  // Query to the store, held from the latched request
  assign acc_valid = s_reg.acc_valid;
  assign acc_commit = s_reg.acc_commit;
  assign acc_op = s_reg.op;
  assign acc_num = s_reg.num;
  assign acc_elem = s_reg.q1[`SUB_HI:`SUB_LO];
  assign acc_dword = s_reg.dw;
  assign acc_value = s_reg.qv;
  assign acc_conn_obj = s_reg.qv[`CONN_OBJ_HI:`CONN_OBJ_LO];
  assign acc_conn_idx = s_reg.qv[`CONN_IDX_HI:`CONN_IDX_LO];
endmodule // param_channel_request_codec

// ---- sim/param_store_model.sv ----
// Parameter store stand-in: answers each lookup or commit exactly once.
// Assumes the bench sets the descriptor, cause, value and delay knobs.
`timescale 1ns/1ps
module param_store_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Queries from the codec
  input wire logic acc_valid,
  input wire logic acc_commit,
  // Bench knobs
  input wire logic slow,
  input wire logic [7:0] cfg_desc,
  input wire param_codec_pkg::cause_t cfg_cause,
  input wire logic [31:0] cfg_value,
  // Answers to the codec
  output logic ack_valid,
  output logic [7:0] ack_desc,
  output param_codec_pkg::cause_t ack_cause,
  output logic [31:0] ack_value
);
  import param_codec_pkg::*;
  logic [2:0] cnt_reg;
  // Descriptor follows the bench knobs
  assign ack_desc = cfg_desc;
  assign ack_cause = cfg_cause;
  // Answer two or five cycles after a query; value is junk outside it
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 3'h0;
      ack_valid <= 1'b0;
      ack_value <= 32'h0;
    end else begin
      ack_valid <= (cnt_reg == 3'h1);
      ack_value <= (cnt_reg == 3'h1) ? cfg_value : ~cfg_value;
      if (acc_valid || acc_commit)
        cnt_reg <= slow ? 3'h4 : 3'h1;
      else if (cnt_reg != 3'h0)
        cnt_reg <= cnt_reg - 3'h1;
    end
  end
endmodule // param_store_model

// ---- sim/param_codec_sva.sv ----
// Checker of the parameter channel codec at its ports.
// Assumes a bind to the codec top module, ports matched by name.
`timescale 1ns/1ps
module param_codec_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Request and response
  input wire logic req_valid,
  input wire logic [15:0] req_w0,
  input wire logic [15:0] req_w1,
  input wire logic [15:0] req_w3,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_w0,
  input wire logic [15:0] rsp_w1,
  input wire logic [15:0] rsp_w2,
  input wire logic [15:0] rsp_w3,
  input wire logic [2:0] rsp_len,
  // Store side
  input wire logic acc_valid,
  input wire logic acc_commit,
  input wire logic acc_dword,
  input wire param_codec_pkg::acc_op_t acc_op,
  input wire logic [15:0] acc_num,
  input wire logic [7:0] acc_elem,
  input wire logic [5:0] acc_conn_obj,
  input wire logic [9:0] acc_conn_idx,
  input wire logic ack_valid,
  input wire logic [31:0] ack_value
);
  import param_codec_pkg::*;
  logic [15:0] q0_reg, q1_reg, q3_reg;
  logic [31:0] av_reg;
  logic rd_reg, pv_reg;
  wire err = rsp_valid && rsp_w0[15:12] == 4'h7;
  // Lookup raised right after a taken request
  wire lk = acc_valid && pv_reg;
  // Last request words, last store value, read flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q0_reg <= 16'h0;
      q1_reg <= 16'h0;
      q3_reg <= 16'h0;
      av_reg <= 32'h0;
      rd_reg <= 1'b0;
      pv_reg <= 1'b0;
    end else begin
      pv_reg <= req_valid;
      if (req_valid) {q0_reg, q1_reg, q3_reg} <= {req_w0, req_w1, req_w3};
      if (ack_valid) av_reg <= ack_value;
      if (acc_valid) rd_reg <= (acc_op == OP_READ);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Response word layout
  // ****
  a_rsv_zero: assert property (rsp_valid |-> !rsp_w0[11])
    else $error("reserved bit set");
  a_err_form: assert property (err && rsp_len == 3'h4 |->
    rsp_w2 == 16'h0 && rsp_w3[15:8] == 8'h0) else $error("bad error words");
  a_err_echo: assert property (err |-> rsp_w0[10:0] == q0_reg[10:0]
    && rsp_w1 == q1_reg) else $error("error echo wrong");
  a_dword_pack: assert property (rsp_valid && rsp_w0[15:12] == 4'h2
    && rd_reg |-> rsp_len == 3'h4 && {rsp_w2, rsp_w3} == av_reg)
    else $error("double word misplaced");
  // ****
  // Request decode
  // ****
  a_num_low: assert property (lk && q1_reg[15:8] == 8'h0 |->
    acc_num == {5'h0, q0_reg[10:0]}) else $error("number field wrong");
  a_num_page: assert property (lk && q1_reg[15:8] == 8'h90 |->
    acc_num == 16'h1770 + q0_reg[10:0]) else $error("page offset wrong");
  a_elem_sel: assert property (lk |-> acc_elem == q1_reg[7:0])
    else $error("element wrong");
  a_conn_split: assert property (lk |-> acc_conn_obj == q3_reg[15:10]
    && acc_conn_idx == q3_reg[9:0]) else $error("connector split wrong");
  a_dword_flag: assert property (lk |-> acc_dword ==
    (q0_reg[15:12] == 4'h3 || q0_reg[15:12] == 4'h8))
    else $error("width flag wrong");
  a_commit_op: assert property (acc_commit |-> acc_op == OP_WRITE
    && $past(ack_valid)) else $error("commit out of turn");
  c_err: cover property (err);
  c_dword: cover property (rsp_valid && rsp_w0[15:12] == 4'h2);
  c_page: cover property (lk && q1_reg[15:8] == 8'h74);
endmodule // param_codec_sva

// ---- sim/tb.sv ----
// Bench of the parameter channel codec: reads, writes, refusals, registers.
// Assumes the store model and the checker are compiled beforehand.
`timescale 1ns/1ps
module tb;
  import param_codec_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, acc_value, ack_value;
  logic req_valid = 1'b0, slow = 1'b0, four = 1'b1;
  logic [15:0] req_w0 = 16'h0, req_w1 = 16'h0, req_w2 = 16'h0;
  logic [15:0] req_w3 = 16'h0, rsp_w0, rsp_w1, rsp_w2, rsp_w3, acc_num;
  logic rsp_valid, acc_valid, acc_commit, acc_dword, ack_valid;
  logic [2:0] rsp_len;
  acc_op_t acc_op;
  cause_t cause = C_NONE, ack_cause;
  logic [7:0] acc_elem, ack_desc, desc = 8'h80, ack_elems = 8'h1;
  logic [31:0] val = 32'h0;
  logic [5:0] acc_conn_obj;
  logic [9:0] acc_conn_idx;
  logic [15:0] f, seen_num;
  logic [63:0] w;
  int seed = 32'hcb25;
  int n_fail = 0, check_count = 0, n_err = 0;
  logic [7:0] pg [8] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'ha0, 8'h50, 8'hf0,
    8'h74};
  logic [15:0] ofs [8] = '{16'd0, 16'd2000, 16'd6000, 16'd8000, 16'd10000,
    16'd20000, 16'd30000, 16'd60000};
  logic [7:0] cc [12] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h07, 8'h0c, 8'h11,
    8'h14, 8'h65, 8'h68, 8'hc8, 8'hc9};
  // Clock
  always #2.5 ref_clk = ~ref_clk;
  param_channel_request_codec i_dut (.*, .ack_exists(ack_desc[7]),
    .ack_indexed(ack_desc[6]), .ack_reset_only(ack_desc[5]),
    .ack_needs_stop(ack_desc[4]), .ack_commission(ack_desc[3]),
    .ack_dword(ack_desc[2]), .ack_byte(ack_desc[1]), .ack_conn(ack_desc[0]));
  param_store_model i_store (.ref_clk, .reset_n, .acc_valid, .acc_commit,
    .slow, .cfg_desc(desc), .cfg_cause(cause), .cfg_value(val), .ack_valid,
    .ack_desc, .ack_cause, .ack_value);
  // Number seen by the store
  always @(posedge ref_clk) if (acc_valid) seen_num <= acc_num;
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(64'(reg_rdata), 64'(e));
    @(posedge ref_clk);
  endtask
  function automatic logic [63:0] rq(input logic [3:0] id,
      input logic [15:0] n, x, input logic [31:0] v);
    return {id, 1'b0, n[10:0], x, v};
  endfunction
  task automatic go(input logic [63:0] q, e, input logic [2:0] n);
    int k = 0;
    {req_w0, req_w1, req_w2, req_w3} <= q;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && k < 60) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k == 60) n_fail++;
    chk({rsp_w0, rsp_w1, rsp_w2, rsp_w3}, e);
    chk(64'(rsp_len), 64'(n));
    @(posedge ref_clk);
  endtask
  task automatic ek(input logic [63:0] q, input logic [7:0] c);
    n_err++;
    go(q, four ? {4'h7, 1'b0, q[58:32], 24'h0, c} :
      {4'h7, 1'b0, q[58:32], 8'h0, c, 16'h0}, four ? 3'h4 : 3'h3);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(4'h0, 32'h6);
    rd(4'h1, 32'h0);
    for (int i = 0; i < 10; i++) begin
      f = 16'({$random(seed)} % 32'd2000);
      val <= $random(seed);
      desc <= i > 7 ? (i[0] ? 8'h81 : 8'h84) : (i[0] ? 8'h82 : 8'h80);
      slow <= i[1];
      @(posedge ref_clk);
      if (i < 8) go(rq(4'h1, f, 16'h0, 32'h0), {4'h1, 1'b0, f[10:0], 32'h0,
        i[0] ? {8'h0, val[7:0]} : val[15:0]}, 3'h4);
      else go(rq(4'h1, f, 16'h0, 32'h0), {4'h2, 1'b0, f[10:0], 16'h0, val},
        3'h4);
    end
    desc <= 8'h80;
    for (int i = 0; i < 8; i++) begin
      go(rq(4'h1, 16'h5, {pg[i], 8'h0}, 32'h0), {16'h1005, pg[i], 8'h0,
        16'h0, val[15:0]}, 3'h4);
      chk(64'(seen_num), 64'(16'h5 + ofs[i]));
    end
    w = rq(4'h2, 16'h5, 16'h0, 32'h1);
    ek(rq(4'h1, 16'h5, 16'h1100, 32'h0), 8'h00);
    ek(rq(4'h5, 16'h5, 16'h0, 32'h0), 8'h6a);
    ek(rq(4'h1, 16'h5, 16'h1, 32'h0), 8'h04);
    desc <= 8'h00;
    ek(rq(4'h1, 16'h5, 16'h0, 32'h0), 8'h00);
    desc <= 8'hc0;
    ack_elems <= 8'h2;
    ek(rq(4'h1, 16'h5, 16'h2, 32'h0), 8'h03);
    desc <= 8'h80;
    wr(4'h0, 32'h16);
    ek(rq(4'h1, 16'h5, 16'h0, 32'h0), 8'h87);
    wr(4'h0, 32'h02);
    ek(w, 8'h0b);
    wr(4'h0, 32'h06);
    ek(w, 8'hcc);
    wr(4'h0, 32'h26);
    desc <= 8'h84;
    ek(w, 8'h05);
    desc <= 8'ha0;
    ek(w, 8'h06);
    wr(4'h0, 32'h2e);
    desc <= 8'h90;
    ek(w, 8'h6b);
    wr(4'h0, 32'h26);
    desc <= 8'h88;
    ek(w, 8'h86);
    wr(4'h4, 32'h0f);
    go(w, {16'h1005, 48'h1}, 3'h4);
    desc <= 8'h80;
    for (int i = 1; i < 12; i++) begin
      cause <= cause_t'(i);
      ek(w, cc[i]);
    end
    cause <= C_NONE;
    wr(4'h0, 32'h25);
    four = 1'b0;
    desc <= 8'h84;
    ek(rq(4'h1, 16'h5, 16'h0, 32'h0), 8'h66);
    desc <= 8'h80;
    go(rq(4'h1, 16'h5, 16'h0, 32'h0), {16'h1005, 16'h0, val[15:0],
      16'h0}, 3'h3);
    rd(4'hc, 32'(n_err));
    finish_test;
  end
endmodule // tb
bind param_channel_request_codec param_codec_sva i_sva (.*);
